/* rtl/tprm_pkg.sv */
// Shared constants and types for the test port reset and mode latch pair
package tprm_pkg;
  // Memory-mapped identification register
  localparam logic [31:0] TPRM_CHIP_ID_ADDR = 32'h01c4_0028;
  // Identity values are arbitrary; bit 0 stays set as a scan identifier requires
  localparam logic [3:0]  TPRM_CHIP_REV     = 4'h3;
  localparam logic [27:0] TPRM_CHIP_PART    = 28'h5e1_a0c1;
  localparam logic [31:0] TPRM_CHIP_ID      = {TPRM_CHIP_REV, TPRM_CHIP_PART};
  localparam logic [3:0]  TPRM_REV_UNKNOWN  = 4'h0;

  // Strap pair value that selects boundary-scan mode; anything else is emulation
  localparam logic [1:0]  TPRM_MODE_BSCAN   = 2'h0;

  // Scan instructions
  localparam logic [3:0]  TPRM_IR_IDCODE    = 4'h1;
  localparam logic [3:0]  TPRM_IR_CAPTURE   = 4'h1;

  // Controller register offsets and fields
  localparam logic [7:0]  TPRM_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  TPRM_OFF_CMD      = 8'h04;
  localparam logic [7:0]  TPRM_OFF_DATA_IN  = 8'h08;
  localparam logic [7:0]  TPRM_OFF_DATA_OUT = 8'h0c;
  localparam logic [7:0]  TPRM_OFF_STATUS   = 8'h10;
  localparam int          TPRM_CTRL_TRST    = 0;
  localparam int          TPRM_CTRL_TRST_OE = 1;
  localparam int          TPRM_CTRL_STRAP   = 2;
  localparam int          TPRM_CTRL_SYSRUN  = 4;
  localparam logic [4:0]  TPRM_CTRL_RESET   = 5'h02;
  localparam logic [1:0]  TPRM_OP_RESET     = 2'h0;
  localparam logic [1:0]  TPRM_OP_IR        = 2'h1;
  localparam logic [1:0]  TPRM_OP_DR        = 2'h2;

  // Scan sequence shapes, counted in test clock edges
  localparam logic [5:0]  TPRM_PRE_DR       = 6'h03;
  localparam logic [5:0]  TPRM_PRE_IR       = 6'h04;
  localparam logic [5:0]  TPRM_LEN_DR       = 6'h20;
  localparam logic [5:0]  TPRM_LEN_IR       = 6'h04;
  localparam logic [5:0]  TPRM_TAIL         = 6'h02;
  localparam logic [5:0]  TPRM_RESET_ONES   = 6'h05;
  localparam logic [5:0]  TPRM_RESET_LEN    = 6'h06;

  // Test clock made by the controller: half period rounded up to whole cycles
  localparam int          TPRM_CLK_NS       = 8;
  localparam int          TPRM_TCK_MIN_NS   = 50;
  localparam int          TPRM_TCK_HALF     = (TPRM_TCK_MIN_NS / 2 + TPRM_CLK_NS - 1)
                                              / TPRM_CLK_NS;
  localparam logic [3:0]  TPRM_TCK_HALF_M1  = 4'(TPRM_TCK_HALF - 1);

  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PAU_DR = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'ha,
    TAP_SH_IR  = 4'hb,
    TAP_EX1_IR = 4'hc,
    TAP_PAU_IR = 4'hd,
    TAP_EX2_IR = 4'he,
    TAP_UPD_IR = 4'hf
  } tprm_tap_t;
endpackage

/* rtl/tprm_link_if.sv */
// Test port link between the scan controller and the device
`timescale 1ns/10ps
interface tprm_link_if;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo_o;
  logic       tdo_oe;
  logic       tdo;
  logic       trst_o;
  logic       trst_oe;
  logic       trst_pd;
  logic       trst_n;
  logic [1:0] mode_strap_pair;

  // Undriven test reset falls to the device pull-down level
  assign trst_n = trst_oe ? trst_o : !trst_pd;
  assign tdo    = tdo_oe ? tdo_o : 1'b1;

  modport dev (input tck, tms, tdi, trst_n, mode_strap_pair,
               output tdo_o, tdo_oe, trst_pd);
  modport ctl (output tck, tms, tdi, trst_o, trst_oe, mode_strap_pair,
               input tdo);
endinterface

/* rtl/tprm_device.sv */
// Device end: test access port, strap mode latch and identification register
//
// Register access over plain read and write strobes was chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// R01: Both resets held during power-up
// R02: System reset functional logic; test reset port
// R03: Device runs while test reset stays asserted
// R04: Test reset sampled on running test clock
// R05: Identifier variant valid only after system reset
// R06: Other scan instructions ignore system reset
// R07: Test reset input weakly pulled asserted
// R08: Controller pulses test reset before scanning
// R09: Straps captured on test reset rising edge; here a rising edge is ignored while system reset is held
// R10: Captured straps pick scan or emulation mode
// R11: Read-only identifier at fixed address
// R12: Top identifier digit is silicon revision
// R13: Latched mode holds until next rising edge; here a system reset also clears it
module tprm_device
  import tprm_pkg::*;
(
  tprm_link_if.dev    link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_addr,
  output      logic [31:0] reg_rdata,
  output      logic        reg_ack,
  output      logic        mode_bscan,
  output      logic        mode_emu,
  output      logic        tap_in_reset
);

  // System side, reset by the system reset only
  logic        sys_run;
  logic [1:0]  mode_p1;
  logic [1:0]  mode_p2;
  logic        valid_p1;
  logic        valid_p2;

  // Test clock side; the port is reset by the synchronised test reset, the strap latch by the synchronised system reset
  logic        trst_s1;
  logic        trst_s2;
  logic        trst_s3;
  logic        run_s1;
  logic        run_s2;
  logic [1:0]  strap_s1;
  logic [1:0]  strap_s2;
  logic [1:0]  mode_lat;
  logic        mode_valid;
  tprm_tap_t   tap;
  tprm_tap_t   next_tap;
  logic [3:0]  ir;
  logic [3:0]  ir_sh;
  logic [31:0] dr_sh;
  logic        tdo_q;
  logic        tdo_en_q;

  wire         trst_rise   = trst_s2 && !trst_s3;
  wire         id_sel      = (ir == TPRM_IR_IDCODE);
  wire         reg_hit     = (reg_addr == TPRM_CHIP_ID_ADDR);
  wire  [3:0]  scan_rev    = run_s2 ? TPRM_CHIP_REV : TPRM_REV_UNKNOWN;
  wire  [31:0] scan_id     = {scan_rev, TPRM_CHIP_PART};
  wire         in_sh_ir    = (tap == TAP_SH_IR);
  wire         in_shift    = in_sh_ir || (tap == TAP_SH_DR);
  wire         next_tdo    = in_sh_ir ? ir_sh[0] : dr_sh[0];

  assign link.trst_pd = 1'b1;                              // [R07]
  assign link.tdo_o   = tdo_q;
  assign link.tdo_oe  = tdo_en_q;

  function automatic tprm_tap_t tap_step(tprm_tap_t s, logic m);
    case (s)
      TAP_RESET:  tap_step = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_step = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_step = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_step = TAP_RESET;
    endcase
  endfunction

  assign next_tap = tap_step(tap, link.tms);

  // System reset release marks the identifier variant as trustworthy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_run <= 1'b0;                                     // [R02]
    end else begin
      sys_run <= 1'b1;                                     // [R05]
    end
  end

  // Fixed identifier; writes are acknowledged and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_rdata <= 32'h0;
      reg_ack   <= 1'b0;
    end else begin
      reg_rdata <= (reg_rd && reg_hit) ? TPRM_CHIP_ID : 32'h0;  // [R11] [R12]
      reg_ack   <= reg_rd || reg_wr;
    end
  end

  // Mode bits change only at a test reset edge or a system reset, so a plain per-bit
  // synchroniser is safe once the valid flag has settled with them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_p1    <= 2'h0;
      mode_p2    <= 2'h0;
      valid_p1   <= 1'b0;
      valid_p2   <= 1'b0;
      mode_bscan <= 1'b0;
      mode_emu   <= 1'b0;
    end else begin
      mode_p1    <= mode_lat;
      mode_p2    <= mode_p1;
      valid_p1   <= mode_valid;
      valid_p2   <= valid_p1;
      mode_bscan <= valid_p2 && (mode_p2 == TPRM_MODE_BSCAN);   // [R10]
      mode_emu   <= valid_p2 && (mode_p2 != TPRM_MODE_BSCAN);   // [R10]
    end
  end

  // Pin synchronisers on the test clock; test reset is only seen while
  // the test clock runs, which is why the controller keeps it going
  always_ff @(posedge link.tck) begin
    trst_s1  <= link.trst_n;                               // [R04]
    trst_s2  <= trst_s1;
    trst_s3  <= trst_s2;
    run_s1   <= sys_run;
    run_s2   <= run_s1;
    strap_s1 <= link.mode_strap_pair;
    strap_s2 <= strap_s1;
  end

  // Strap latch; a system reset forgets the mode until the next edge
  always_ff @(posedge link.tck) begin
    if (!run_s2) begin
      mode_valid <= 1'b0;
      mode_lat   <= TPRM_MODE_BSCAN;
    end else if (trst_rise) begin
      mode_valid <= 1'b1;                                  // [R09]
      mode_lat   <= strap_s2;                              // [R09] [R13]
    end
  end

  // Test access port, reset only by the test reset
  always_ff @(posedge link.tck) begin
    if (!trst_s2) begin
      tap <= TAP_RESET;                                    // [R02] [R03] [R04]
      ir  <= TPRM_IR_IDCODE;
    end else begin
      tap <= next_tap;
      if (tap == TAP_UPD_IR) begin
        ir <= ir_sh;
      end else if (tap == TAP_RESET) begin
        ir <= TPRM_IR_IDCODE;
      end
    end
  end

  // Bypass and other paths work without regard to the system reset
  always_ff @(posedge link.tck) begin
    if (!trst_s2) begin
      ir_sh <= TPRM_IR_CAPTURE;
      dr_sh <= 32'h0;
    end else begin
      case (tap)
        TAP_CAP_IR: ir_sh <= TPRM_IR_CAPTURE;
        TAP_SH_IR:  ir_sh <= {link.tdi, ir_sh[3:1]};
        default:    ir_sh <= ir_sh;
      endcase
      if (tap == TAP_CAP_DR) begin
        dr_sh <= id_sel ? scan_id : 32'h0;                 // [R05] [R06]
      end else if (tap == TAP_SH_DR && id_sel) begin
        dr_sh <= {link.tdi, dr_sh[31:1]};
      end else if (tap == TAP_SH_DR) begin
        dr_sh <= {31'h0, link.tdi};                        // [R06]
      end
    end
  end

  // Scan output changes on the falling edge, half a period ahead of sampling
  always_ff @(negedge link.tck) begin
    if (!trst_s2) begin
      tdo_q    <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q    <= next_tdo;
      tdo_en_q <= in_shift;
    end
  end

  assign tap_in_reset = (tap == TAP_RESET);

endmodule

/* rtl/tprm_ctrl.sv */
// Controller end: APB registers, test clock divider and scan sequencer
`timescale 1ns/10ps
module tprm_ctrl
  import tprm_pkg::*;
(
  tprm_link_if.ctl    link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        dev_sys_rst_n
);

  logic [4:0]  ctrl;
  logic [31:0] data_in;
  logic [31:0] data_out;
  logic [31:0] cap;
  logic [1:0]  op;
  logic        busy;
  logic        armed;
  logic [5:0]  idx;
  logic [3:0]  div;
  logic        tck_q;
  logic        tms_q;
  logic        tdi_q;
  logic        tdo_s1;
  logic        tdo_s2;

  wire  [7:0]  off      = paddr[7:0];
  wire         mapped   = (paddr[31:8] == 24'h0) && (off[1:0] == 2'h0)
                          && (off <= TPRM_OFF_STATUS);
  wire         setup    = psel && !penable;
  wire         wr_en    = psel && penable && pwrite && mapped;
  wire         cmd_go   = wr_en && (off == TPRM_OFF_CMD) && !busy;
  wire         wrap     = (div == TPRM_TCK_HALF_M1);
  wire         fall_ev  = wrap && tck_q;
  wire         rise_ev  = wrap && !tck_q;
  wire  [5:0]  pre      = (op == TPRM_OP_IR) ? TPRM_PRE_IR : TPRM_PRE_DR;
  wire  [5:0]  n_bits   = (op == TPRM_OP_IR) ? TPRM_LEN_IR : TPRM_LEN_DR;
  wire  [5:0]  last_sh  = pre + n_bits - 6'h01;
  wire  [5:0]  last_idx = (op == TPRM_OP_RESET) ? TPRM_RESET_LEN - 6'h01
                                                : last_sh + TPRM_TAIL;
  wire         in_sh    = (op != TPRM_OP_RESET) && (idx >= pre) && (idx <= last_sh);
  wire  [5:0]  sh_pos   = idx - pre;
  wire         pre_tms  = (op == TPRM_OP_IR) ? (idx < 6'h02) : (idx == 6'h00);
  wire         tms_now  = (op == TPRM_OP_RESET) ? (idx < TPRM_RESET_ONES)
                        : (idx < pre) ? pre_tms
                        : in_sh ? (idx == last_sh)
                        : (idx == last_sh + 6'h01);
  wire         tdi_now  = in_sh && data_in[sh_pos[4:0]];
  wire  [31:0] out_word = (op == TPRM_OP_IR) ? {28'h0, cap[31:28]} : cap;
  wire  [31:0] rd_word  = (off == TPRM_OFF_CTRL)     ? {27'h0, ctrl}
                        : (off == TPRM_OFF_CMD)      ? {30'h0, op}
                        : (off == TPRM_OFF_DATA_IN)  ? data_in
                        : (off == TPRM_OFF_DATA_OUT) ? data_out
                        : (off == TPRM_OFF_STATUS)   ? {31'h0, busy}
                        : 32'h0;

  // Zero wait states; read data is registered during the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign link.tck             = tck_q;
  assign link.tms             = tms_q;
  assign link.tdi             = tdi_q;
  assign link.trst_o          = ctrl[TPRM_CTRL_TRST];
  assign link.trst_oe         = ctrl[TPRM_CTRL_TRST_OE];
  assign link.mode_strap_pair = ctrl[TPRM_CTRL_STRAP +: 2];
  assign dev_sys_rst_n        = ctrl[TPRM_CTRL_SYSRUN];

  // Reset value drives test reset low and holds the system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= TPRM_CTRL_RESET;                          // [R01]
      data_in <= 32'h0;
      prdata  <= 32'h0;
    end else begin
      if (wr_en && off == TPRM_OFF_CTRL) begin
        ctrl <= pwdata[4:0];                               // [R08] [R09]
      end
      if (wr_en && off == TPRM_OFF_DATA_IN) begin
        data_in <= pwdata;
      end
      if (setup) begin
        prdata <= mapped ? rd_word : 32'h0;
      end
    end
  end

  // Free-running test clock, so test reset is always clocked in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div   <= 4'h0;
      tck_q <= 1'b0;
    end else begin
      div   <= wrap ? 4'h0 : div + 4'h1;
      tck_q <= wrap ? !tck_q : tck_q;                      // [R04]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_s1 <= 1'b1;
      tdo_s2 <= 1'b1;
    end else begin
      tdo_s1 <= link.tdo;
      tdo_s2 <= tdo_s1;
    end
  end

  // Drive on the falling edge, sample and advance on the rising one;
  // a command only starts counting after it has driven its first bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op       <= TPRM_OP_RESET;
      busy     <= 1'b0;
      armed    <= 1'b0;
      idx      <= 6'h00;
      tms_q    <= 1'b1;
      tdi_q    <= 1'b0;
      cap      <= 32'h0;
      data_out <= 32'h0;
    end else if (cmd_go) begin
      op    <= pwdata[1:0];
      busy  <= 1'b1;
      armed <= 1'b0;
      idx   <= 6'h00;
    end else if (busy && fall_ev) begin
      tms_q <= tms_now;
      tdi_q <= tdi_now;
      armed <= 1'b1;
    end else if (busy && armed && rise_ev) begin
      if (in_sh) begin
        cap <= {tdo_s2, cap[31:1]};
      end
      if (idx == last_idx) begin
        busy     <= 1'b0;
        armed    <= 1'b0;
        data_out <= out_word;
      end else begin
        idx <= idx + 6'h01;
      end
    end
  end

endmodule

/* test/tprm_checker.sv */
// Concurrent checks on the test port link between controller and device
`timescale 1ns/10ps
module tprm_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdi,
  input wire logic       tdo_o,
  input wire logic       tdo_oe,
  input wire logic       tdo,
  input wire logic       trst_o,
  input wire logic       trst_oe,
  input wire logic       trst_pd,
  input wire logic       trst_n,
  input wire logic [1:0] mode_strap_pair
);
  // The test clock must keep running with an even 4 pclk half period
  tck_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tck) |-> tck[*4] ##1 !tck) else $error("test clock high phase wrong");
  tck_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(tck) |-> !tck[*4] ##1 tck) else $error("test clock low phase wrong");
  trst_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    trst_pd) else $error("test reset pull not enabled");
  trst_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    !trst_oe |-> !trst_n) else $error("undriven test reset not asserted");
  boot_trst_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !trst_n) else $error("test reset not held at power up");
  // Synchroniser depth lets the port drop its driver only after a few test clocks
  scan_quiet_a: assert property (@(posedge tck) disable iff (!presetn)
    !trst_n [*4] |-> !tdo_oe) else $error("scan out driven while test reset held");
  tdo_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tdo_oe |-> tdo) else $error("released scan out not high");
  oe_at_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(tdo_oe) |-> !tck) else $error("scan out enable moved with clock high");
  out_at_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(tdo_o) |-> !tck) else $error("scan out moved with clock high");
endmodule

/* test/test_port_reset_mode_latch_tb.sv */
// Testbench joining the controller and device ends of the test port link
`timescale 1ns/10ps
module test_port_reset_mode_latch_tb
  import tprm_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        reg_rd = 1'b0, reg_wr = 1'b0, err;
  logic        pready, pslverr, dev_sys_rst_n, reg_ack, mode_bscan, mode_emu, tap_in_reset;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, reg_addr = 32'h0;
  logic [31:0] prdata, reg_rdata, r, d;
  logic [31:0] bad [3] = '{32'h14, 32'h2, 32'h104};
  logic [3:0]  ins;
  logic [1:0]  s;
  int          fail_count = 0, cmp_count = 0, seed;

  tprm_link_if u_tprm_link_if ();
  tprm_ctrl u_tprm_ctrl (.link(u_tprm_link_if), .pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_sys_rst_n(dev_sys_rst_n));
  // Device system reset comes from the controller so software owns the boot
  tprm_device u_tprm_device (.link(u_tprm_link_if), .pclk(pclk), .presetn(dev_sys_rst_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .mode_bscan(mode_bscan), .mode_emu(mode_emu),
    .tap_in_reset(tap_in_reset));
  tprm_checker u_tprm_checker (.pclk(pclk), .presetn(presetn), .tck(u_tprm_link_if.tck),
    .tms(u_tprm_link_if.tms), .tdi(u_tprm_link_if.tdi), .tdo_o(u_tprm_link_if.tdo_o),
    .tdo_oe(u_tprm_link_if.tdo_oe), .tdo(u_tprm_link_if.tdo),
    .trst_o(u_tprm_link_if.trst_o), .trst_oe(u_tprm_link_if.trst_oe),
    .trst_pd(u_tprm_link_if.trst_pd), .trst_n(u_tprm_link_if.trst_n),
    .mode_strap_pair(u_tprm_link_if.mode_strap_pair));

  always #4 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Waits on pready without a bound of its own; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input logic t, input logic oe, input logic [1:0] st, input logic run);
    apb(1'b1, {24'h0, TPRM_OFF_CTRL}, {27'h0, run, st, oe, t});
  endtask

  // Polls busy until it clears; a stuck sequencer is caught by the watchdog
  task automatic scan(input logic [1:0] op, input logic [31:0] din);
    apb(1'b1, {24'h0, TPRM_OFF_DATA_IN}, din);
    apb(1'b1, {24'h0, TPRM_OFF_CMD}, {30'h0, op});
    r = 32'h1;
    while (r[0] !== 1'b0) begin
      apb(1'b0, {24'h0, TPRM_OFF_STATUS}, 32'h0);
    end
    apb(1'b0, {24'h0, TPRM_OFF_DATA_OUT}, 32'h0);
  endtask

  task automatic dev(input logic w, input logic [31:0] a);
    @(posedge pclk);
    reg_rd   <= !w;
    reg_wr   <= w;
    reg_addr <= a;
    @(posedge pclk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk(reg_ack, 1'b1);
    r = reg_rdata;
  endtask

  task automatic wait_mode(input logic [1:0] e);
    int n;
    n = 0;
    while ({mode_bscan, mode_emu} !== e && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask

  function automatic logic [1:0] f_mode(input logic [1:0] st);
    return (st == TPRM_MODE_BSCAN) ? 2'b10 : 2'b01;
  endfunction

  // One-bit bypass stage puts its captured zero ahead of the data
  function automatic logic [31:0] f_byp(input logic [31:0] v);
    return {v[30:0], 1'b0};
  endfunction

  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  initial begin
    seed = $urandom(88);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, {24'h0, TPRM_OFF_CTRL}, 32'h0);
    chk(r, {27'h0, TPRM_CTRL_RESET});
    repeat (40) @(posedge pclk);
    chk(dev_sys_rst_n, 1'b0);
    chk(tap_in_reset, 1'b1);
    chk({mode_bscan, mode_emu}, 2'b00);
    ctl(1'b1, 1'b1, 2'h1, 1'b0);
    repeat (100) @(posedge pclk);
    chk({mode_bscan, mode_emu}, 2'b00);
    ctl(1'b0, 1'b1, 2'h0, 1'b1);
    repeat (40) @(posedge pclk);
    chk(dev_sys_rst_n, 1'b1);
    chk(tap_in_reset, 1'b1);
    dev(1'b0, TPRM_CHIP_ID_ADDR);
    chk(r, {TPRM_CHIP_REV, TPRM_CHIP_PART});
    dev(1'b1, TPRM_CHIP_ID_ADDR);
    dev(1'b0, TPRM_CHIP_ID_ADDR);
    chk(r, TPRM_CHIP_ID);
    dev(1'b0, TPRM_CHIP_ID_ADDR + 32'h4);
    chk(r, 32'h0);
    ctl(1'b1, 1'b0, 2'h0, 1'b1);
    repeat (100) @(posedge pclk);
    chk(tap_in_reset, 1'b1);
    chk({mode_bscan, mode_emu}, 2'b00);
    for (int i = 0; i < 6; i++) begin
      s = (i % 2) ? 2'(i / 2 + 1) : 2'h0;
      ctl(1'b0, 1'b1, s, 1'b1);
      repeat (40) @(posedge pclk);
      ctl(1'b1, 1'b1, s, 1'b1);
      wait_mode(f_mode(s));
      chk({mode_bscan, mode_emu}, f_mode(s));
      ctl(1'b1, 1'b1, 2'($urandom), 1'b1);
      repeat (100) @(posedge pclk);
      chk({mode_bscan, mode_emu}, f_mode(s));
    end
    scan(TPRM_OP_RESET, 32'h0);
    scan(TPRM_OP_DR, $urandom);
    chk(r, TPRM_CHIP_ID);
    for (int i = 0; i < 3; i++) begin
      ins = (i == 0) ? 4'h0 : 4'($urandom_range(15, 2));
      scan(TPRM_OP_IR, {28'h0, ins});
      chk(r[3:0], TPRM_IR_CAPTURE);
      d = (i == 0) ? 32'hffff_ffff : $urandom;
      scan(TPRM_OP_DR, d);
      chk(r, f_byp(d));
      scan(TPRM_OP_RESET, 32'h0);
    end
    chk(tap_in_reset, 1'b0);
    ctl(1'b1, 1'b1, 2'h2, 1'b0);
    repeat (20) @(posedge pclk);
    chk(tap_in_reset, 1'b0);
    chk({mode_bscan, mode_emu}, 2'b00);
    scan(TPRM_OP_IR, 32'h5);
    chk(r[3:0], TPRM_IR_CAPTURE);
    d = $urandom;
    scan(TPRM_OP_DR, d);
    chk(r, f_byp(d));
    scan(TPRM_OP_RESET, 32'h0);
    scan(TPRM_OP_DR, 32'h0);
    chk(r, {TPRM_REV_UNKNOWN, TPRM_CHIP_PART});
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      chk(err, 1'b1);
      chk(r, 32'h0);
    end
    ctl(1'b0, 1'b1, 2'h0, 1'b1);
    repeat (40) @(posedge pclk);
    chk(tap_in_reset, 1'b1);
    end_sim();
  end
endmodule
